// >>> mtp_pkg.sv
package mtp_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 10;          // System clock period
  localparam int MS_NS         = 1000000;     // One millisecond
  localparam int SERVO_NS      = 250000;      // Servo sample period
  localparam int MS_CYCLES     = MS_NS / CLK_PERIOD_NS;     // Cycles per millisecond
  localparam int SERVO_CYCLES  = SERVO_NS / CLK_PERIOD_NS;  // Cycles per servo sample

  ////////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int AXES   = 8;                  // Axes served
  localparam int INPUTS = 80;                 // Digital inputs seen
  localparam int POS_W  = 32;                 // Position and argument width
  localparam int TMO_W  = 16;                 // In-position timeout width, ms

  ////////////////////////////////////////////////////////////////////////////////
  // Input numbering
  localparam int SMALL_AXES_MAX = 4;          // Largest small variant
  localparam int IN_BASE_SMALL  = 8;          // Last base input, small variant
  localparam int IN_BASE_LARGE  = 16;         // Last base input, large variant
  localparam int IN_EXT_FIRST   = 17;         // First extended input
  localparam int IN_EXT_LAST    = 80;         // Last extended input

  ////////////////////////////////////////////////////////////////////////////////
  // Codes and reset values
  localparam logic [7:0]  STOP_CODE_INPOS_TO = 8'h63;  // In-position timeout stop code
  localparam logic [7:0]  STOP_CODE_RST      = 8'h00;  // Stop code after reset
  localparam logic [31:0] TIME_RST           = 32'h0;  // Timers after reset

  // Trip command kinds
  typedef enum logic [3:0] {
    OP_MOTION_DONE,
    OP_REL_DIST,
    OP_INC_DIST,
    OP_ABS_POS,
    OP_FWD_CROSS,
    OP_REV_CROSS,
    OP_IN_POS,
    OP_INPUT,
    OP_SLEW,
    OP_REF_TIME,
    OP_PATH_DIST,
    OP_DELAY
  } mtp_op_t;

  // Evaluator states
  typedef enum logic {
    ST_IDLE,
    ST_WAIT
  } mtp_state_t;

endpackage

// >>> mtp_tick_if.sv
`timescale 1ns/1ps
// One-cycle rate strobe between divider and user
interface mtp_tick_if;
  logic en;                                   // Strobe, one cycle per period
  modport src (output en);
  modport snk (input en);
endinterface

// >>> mtp_tick_div.sv
`timescale 1ns/1ps
module mtp_tick_div #(
  parameter int DIV = 2
)(
  input  wire logic  clk_sys,
  input  wire logic  arst_n,
  mtp_tick_if.src    tick
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

  logic [CW-1:0] cnt;                         // Period counter
  wire           wrap = (cnt == CW'(DIV - 1)); // Last cycle of the period

  ////////////////////////////////////////////////////////////////////////////////
  // Counter and registered strobe
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt     <= '0;
      tick.en <= 1'b0;
    end else begin
      cnt     <= wrap ? '0 : cnt + CW'(1);
      tick.en <= wrap;
    end
  end

  // Strobe never lasts two cycles when DIV is above 1
  a_tick_single: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (DIV > 1 && tick.en) |=> !tick.en) else $error("rate strobe held two cycles");

endmodule // mtp_tick_div

// >>> mtp_sync3.sv
`timescale 1ns/1ps
module mtp_sync3 #(
  parameter int W = 1
)(
  input  wire logic         clk_sys,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1;                           // First stage, read only by s2
  logic [W-1:0] s2;                           // Second stage
  logic [W-1:0] s3;                           // Third stage
  wire  [W-1:0] agree = ~(s2 ^ s3);           // Bits where stages match
  wire  [W-1:0] next_dout = (s2 & agree) | (dout & ~agree);

  ////////////////////////////////////////////////////////////////////////////////
  // Three-stage sampling, change taken once two stages agree
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      s1   <= '0;
      s2   <= '0;
      s3   <= '0;
      dout <= '0;
    end else begin
      s1   <= din;
      s2   <= s1;
      s3   <= s2;
      dout <= next_dout;
    end
  end

endmodule // mtp_sync3

// >>> mtp_sequencer.sv
// Functional notes
// - Hold sequencer while a trip is pending
// - Motion done waits listed axes, else all
// - Relative distance from move start, one axis
// - Incremental distance from last distance trip
// - Absolute position reached on one axis
// - Forward crossing, immediate if already past
// - Reverse crossing, immediate if already past
// - In position: profile done, encoder reached
// - Timeout: clear trip, code 99, jump
// - Input level: positive high, negative low
// - Input numbers 1-8, 1-16, 17-80
// - Slew speed reached on each listed axis
// - Reference time: set, wait, wait-and-rebase
// - Path distance along coordinated vector
// - Plain delay in milliseconds from start
// - Reject relative move while axis moves
// - Positions checked once per servo sample
`timescale 1ns/1ps
module mtp_sequencer import mtp_pkg::*; #(
  parameter int N_AXES    = AXES,
  parameter int N_INPUTS  = INPUTS,
  parameter int MS_DIV    = MS_CYCLES,
  parameter int SERVO_DIV = SERVO_CYCLES
)(
  input  wire logic                               clk_sys,
  input  wire logic                               arst_n,
  input  wire logic                               cmd_valid,
  output logic                                    cmd_ready,
  input  wire mtp_op_t                            cmd_op,
  input  wire logic [N_AXES-1:0]                  cmd_axis_mask,
  input  wire logic                               cmd_seq,
  input  wire logic [POS_W-1:0]                   cmd_arg,
  output logic                                    seq_hold,
  output logic                                    trip_release,
  output logic                                    cmd_error,
  output logic                                    in_position_timeout_handler,
  output logic                                    stop_code_wr,
  output logic [$clog2(N_AXES)-1:0]               stop_code_axis,
  output logic [7:0]                              stop_code,
  input  wire logic                               rel_cmd_valid,
  input  wire logic [$clog2(N_AXES)-1:0]          rel_cmd_axis,
  output logic                                    rel_cmd_accept,
  output logic                                    rel_cmd_reject,
  input  wire logic [N_AXES-1:0]                  prof_moving,
  input  wire logic [N_AXES-1:0]                  prof_at_slew,
  input  wire logic                               seq_moving,
  input  wire logic [N_AXES-1:0][POS_W-1:0]       cmd_position,
  input  wire logic [N_AXES-1:0][POS_W-1:0]       enc_position,
  input  wire logic [POS_W-1:0]                   path_distance,
  input  wire logic [N_AXES-1:0][TMO_W-1:0]       in_position_timeout,
  input  wire logic [N_INPUTS-1:0]                din_pin
);
  localparam int AXW = $clog2(N_AXES);        // Axis index width
  localparam int IW  = $clog2(N_INPUTS);      // Input index width

  ////////////////////////////////////////////////////////////////////////////////
  // Rate strobes and input sampling
  mtp_tick_if ms_tick ();                     // Millisecond strobe
  mtp_tick_if servo_tick ();                  // Servo sample strobe

  mtp_tick_div #(.DIV(MS_DIV)) u_ms_div (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .tick    (ms_tick.src)
  );

  mtp_tick_div #(.DIV(SERVO_DIV)) u_servo_div (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .tick    (servo_tick.src)
  );

  logic [N_INPUTS-1:0] din_s;                 // Inputs after synchroniser

  mtp_sync3 #(.W(N_INPUTS)) u_din_sync (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .din     (din_pin),
    .dout    (din_s)
  );

  wire servo_en = servo_tick.en;              // One cycle per servo sample
  wire ms_en    = ms_tick.en;                 // One cycle per millisecond

  ////////////////////////////////////////////////////////////////////////////////
  // State
  mtp_state_t                 state;          // Idle or waiting
  mtp_op_t                    op_q;           // Pending trip kind
  logic [N_AXES-1:0]          mask_q;         // Axes named by the trip
  logic                       seq_q;          // Coordinated sequence named
  logic [AXW-1:0]             ax_q;           // Single axis of the trip
  logic signed [POS_W-1:0]    target;         // Position, distance or time goal
  logic                       dir_up;         // Approach direction or input level
  logic                       ref_neg;        // Reference wait that rebases
  logic [IW-1:0]              in_idx_q;       // Watched input
  logic [TMO_W-1:0]           tmo_q;          // Timeout of the in-position wait
  logic [31:0]                ms_now;         // Free millisecond count
  logic [31:0]                ref_time;       // Reference time
  logic [31:0]                wt_start;       // Wait start time
  logic signed [POS_W-1:0]    start_pos [N_AXES]; // Commanded position at move start
  logic signed [POS_W-1:0]    inc_ref [N_AXES];   // Last distance trip point
  logic signed [POS_W-1:0]    path_ref;       // Last path distance trip point
  logic [N_AXES-1:0]          moving_q;       // Motion flags, one cycle back
  logic                       seq_moving_q;   // Sequence flag, one cycle back

  // Lowest axis named in a mask
  function automatic logic [AXW-1:0] first_axis(input logic [N_AXES-1:0] m);
    logic [AXW-1:0] r;
    r = '0;
    for (int i = N_AXES - 1; i >= 0; i--) begin
      if (m[i]) r = AXW'(i);
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Command decode at acceptance
  wire                    cmd_take  = cmd_valid && cmd_ready;
  wire [AXW-1:0]          ax_sel    = first_axis(cmd_axis_mask);
  wire signed [POS_W-1:0] arg_s     = $signed(cmd_arg);
  wire [POS_W-1:0]        arg_mag   = arg_s[POS_W-1] ? POS_W'(-arg_s) : cmd_arg;
  wire signed [POS_W-1:0] sel_cmd   = $signed(cmd_position[ax_sel]);
  wire signed [POS_W-1:0] sel_enc   = $signed(enc_position[ax_sel]);
  wire                    one_axis  = $onehot(cmd_axis_mask);
  wire                    need_one  = (cmd_op == OP_REL_DIST) || (cmd_op == OP_INC_DIST) ||
                                      (cmd_op == OP_ABS_POS) || (cmd_op == OP_FWD_CROSS) ||
                                      (cmd_op == OP_REV_CROSS) || (cmd_op == OP_IN_POS);
  // Valid input numbers depend on axis count
  wire [POS_W-1:0]        in_base   = (N_AXES <= SMALL_AXES_MAX) ? POS_W'(IN_BASE_SMALL)
                                                                 : POS_W'(IN_BASE_LARGE);
  wire                    in_ok     = ((arg_mag >= POS_W'(1)) && (arg_mag <= in_base)) ||
                                      ((arg_mag >= POS_W'(IN_EXT_FIRST)) &&
                                       (arg_mag <= POS_W'(IN_EXT_LAST)) &&
                                       (arg_mag <= POS_W'(N_INPUTS)));
  wire                    cmd_bad   = (need_one && !one_axis) ||
                                      ((cmd_op == OP_INPUT) && !in_ok);
  // Goal for each kind
  wire signed [POS_W-1:0] next_target =
      (cmd_op == OP_REL_DIST)  ? start_pos[ax_sel] + arg_s :
      (cmd_op == OP_INC_DIST)  ? inc_ref[ax_sel] + arg_s :
      (cmd_op == OP_PATH_DIST) ? path_ref + arg_s :
      (cmd_op == OP_REF_TIME || cmd_op == OP_DELAY) ? $signed(arg_mag) : arg_s;
  // Direction of approach, or wanted input level
  wire next_dir_up =
      (cmd_op == OP_ABS_POS) ? (arg_s >= sel_cmd) :
      (cmd_op == OP_IN_POS)  ? (arg_s >= sel_enc) :
      (cmd_op == OP_INPUT)   ? !arg_s[POS_W-1] :
      !arg_s[POS_W-1];

  ////////////////////////////////////////////////////////////////////////////////
  // Trip conditions on the pending trip
  wire signed [POS_W-1:0] cur_cmd   = $signed(cmd_position[ax_q]);
  wire signed [POS_W-1:0] cur_enc   = $signed(enc_position[ax_q]);
  wire [31:0]             target_u  = target;
  wire [31:0]             elapsed_r = ms_now - ref_time;
  wire [31:0]             elapsed_w = ms_now - wt_start;
  wire reach_cmd = dir_up ? (cur_cmd >= target) : (cur_cmd <= target);
  wire reach_enc = dir_up ? (cur_enc >= target) : (cur_enc <= target);
  wire c_done  = (mask_q == '0 && !seq_q) ? ~|prof_moving :
                 (~|(prof_moving & mask_q) && !(seq_q && seq_moving));
  wire c_fwd   = cur_enc >= target;
  wire c_rev   = cur_enc <= target;
  wire c_inpos = !prof_moving[ax_q] && reach_enc;
  wire c_input = din_s[in_idx_q] == dir_up;
  wire c_slew  = (prof_at_slew & mask_q) == mask_q;
  wire c_path  = $signed(path_distance) >= target;
  wire cond =
      (op_q == OP_MOTION_DONE) ? c_done :
      (op_q == OP_REL_DIST)    ? reach_cmd :
      (op_q == OP_INC_DIST)    ? reach_cmd :
      (op_q == OP_ABS_POS)     ? reach_cmd :
      (op_q == OP_FWD_CROSS)   ? c_fwd :
      (op_q == OP_REV_CROSS)   ? c_rev :
      (op_q == OP_IN_POS)      ? c_inpos :
      (op_q == OP_INPUT)       ? c_input :
      (op_q == OP_SLEW)        ? c_slew :
      (op_q == OP_REF_TIME)    ? (elapsed_r >= target_u) :
      (op_q == OP_PATH_DIST)   ? c_path :
      (elapsed_w >= target_u);
  wire tmo_hit  = (op_q == OP_IN_POS) && (tmo_q != '0) &&
                  (elapsed_w >= {{(32 - TMO_W){1'b0}}, tmo_q});
  wire eval     = (state == ST_WAIT) && servo_en;
  wire fire     = eval && cond;
  wire time_out = eval && !cond && tmo_hit;

  assign cmd_ready = (state == ST_IDLE);
  assign seq_hold  = (state == ST_WAIT);

  ////////////////////////////////////////////////////////////////////////////////
  // Evaluator state machine
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: begin
          if (cmd_take && !cmd_bad) state <= ST_WAIT;
        end
        ST_WAIT: begin
          if (fire || time_out) state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Latch the trip on acceptance
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      op_q     <= OP_MOTION_DONE;
      mask_q   <= '0;
      seq_q    <= 1'b0;
      ax_q     <= '0;
      target   <= '0;
      dir_up   <= 1'b0;
      ref_neg  <= 1'b0;
      in_idx_q <= '0;
      tmo_q    <= '0;
      wt_start <= TIME_RST;
    end else if (cmd_take && !cmd_bad) begin
      op_q     <= cmd_op;
      mask_q   <= cmd_axis_mask;
      seq_q    <= cmd_seq;
      ax_q     <= ax_sel;
      target   <= next_target;
      dir_up   <= next_dir_up;
      ref_neg  <= arg_s[POS_W-1];
      in_idx_q <= IW'(arg_mag - POS_W'(1));
      tmo_q    <= in_position_timeout[ax_sel];
      wt_start <= ms_now;
    end
  end

  // Millisecond time base and reference
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ms_now   <= TIME_RST;
      ref_time <= TIME_RST;
    end else begin
      if (ms_en) ms_now <= ms_now + 32'h1;
      if (cmd_take && cmd_op == OP_REF_TIME && arg_mag == '0) begin
        ref_time <= ms_now;
      end else if (fire && op_q == OP_REF_TIME && ref_neg) begin
        ref_time <= ref_time + target_u;
      end
    end
  end

  // Move start positions and distance trip points
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      moving_q     <= '0;
      seq_moving_q <= 1'b0;
      path_ref     <= '0;
      for (int i = 0; i < N_AXES; i++) begin
        start_pos[i] <= '0;
        inc_ref[i]   <= '0;
      end
    end else begin
      moving_q     <= prof_moving;
      seq_moving_q <= seq_moving;
      for (int i = 0; i < N_AXES; i++) begin
        if (prof_moving[i] && !moving_q[i]) begin
          start_pos[i] <= $signed(cmd_position[i]);
          inc_ref[i]   <= $signed(cmd_position[i]);
        end
      end
      if (fire && (op_q == OP_INC_DIST || op_q == OP_REL_DIST)) begin
        inc_ref[ax_q] <= target;
      end
      if (seq_moving && !seq_moving_q) begin
        path_ref <= '0;
      end else if (fire && op_q == OP_PATH_DIST) begin
        path_ref <= target;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registered answers to the sequencer
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      trip_release                <= 1'b0;
      cmd_error                   <= 1'b0;
      in_position_timeout_handler <= 1'b0;
      stop_code_wr                <= 1'b0;
    end else begin
      trip_release                <= fire;
      cmd_error                   <= cmd_take && cmd_bad;
      in_position_timeout_handler <= time_out;
      stop_code_wr                <= time_out;
    end
  end

  // Stop code of the timed-out axis
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      stop_code      <= STOP_CODE_RST;
      stop_code_axis <= '0;
    end else if (time_out) begin
      stop_code      <= STOP_CODE_INPOS_TO;
      stop_code_axis <= ax_q;
    end
  end

  // Relative move check against axis motion
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rel_cmd_accept <= 1'b0;
      rel_cmd_reject <= 1'b0;
    end else begin
      rel_cmd_accept <= rel_cmd_valid && !prof_moving[rel_cmd_axis];
      rel_cmd_reject <= rel_cmd_valid && prof_moving[rel_cmd_axis];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  sequence s_tmo_seen;
    (state == ST_WAIT) && servo_en && !cond && tmo_hit;
  endsequence

  sequence s_tmo_answer;
    in_position_timeout_handler && stop_code_wr && !trip_release &&
    (stop_code == STOP_CODE_INPOS_TO) && cmd_ready ##1 !in_position_timeout_handler;
  endsequence

  a_hold_between_samples: assert property (
    (state == ST_WAIT && !servo_en) |=> seq_hold) else $error("hold dropped off sample");
  a_release_first_sample: assert property (
    (state == ST_WAIT && servo_en && cond) |=> trip_release && cmd_ready ##1 !trip_release)
    else $error("release missed on true sample");
  a_done_axes_busy: assert property (
    (state == ST_WAIT && op_q == OP_MOTION_DONE && servo_en && |(prof_moving & mask_q))
    |=> !trip_release && seq_hold) else $error("motion done released while moving");
  a_inc_point_moves: assert property (
    (state == ST_WAIT && op_q == OP_INC_DIST && servo_en && cond)
    |=> inc_ref[ax_q] == $past(target)) else $error("increment point not advanced");
  a_fwd_past_trips: assert property (
    (state == ST_WAIT && op_q == OP_FWD_CROSS && servo_en && cur_enc >= target)
    |=> trip_release) else $error("forward crossing not tripped");
  a_inpos_timeout: assert property (
    s_tmo_seen |=> s_tmo_answer) else $error("in-position timeout answer wrong");
  a_input_level: assert property (
    (state == ST_WAIT && op_q == OP_INPUT && servo_en && din_s[in_idx_q] != dir_up)
    |=> !trip_release) else $error("input wait released at wrong level");
  a_input_range: assert property (
    (cmd_take && cmd_op == OP_INPUT && !in_ok) |=> cmd_error && !seq_hold)
    else $error("bad input number accepted");
  a_ref_rebase: assert property (
    (state == ST_WAIT && op_q == OP_REF_TIME && ref_neg && servo_en && cond)
    |=> ref_time == $past(ref_time) + $past(target_u)) else $error("reference not moved");
  a_delay_early: assert property (
    (state == ST_WAIT && op_q == OP_DELAY && servo_en && elapsed_w < target_u)
    |=> !trip_release) else $error("delay released early");
  a_rel_reject: assert property (
    (rel_cmd_valid && prof_moving[rel_cmd_axis]) |=> rel_cmd_reject && !rel_cmd_accept)
    else $error("relative move accepted while moving");

endmodule // mtp_sequencer

// >>> mtp_axis_model.sv
`timescale 1ns/1ps
// Profiler stand-in for axis 0: ramps one count a cycle
module mtp_axis_model (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        go,
  input  wire logic [31:0] target,
  output logic             moving,
  output logic [31:0]      pos
);
  // Runs until the target is met or the bench stops it
  assign moving = go && (pos != target);
  // Position ramp, feedback equals command
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) pos <= 32'h0;
    else if (moving) pos <= pos + 32'h1;
  end
endmodule // mtp_axis_model

// >>> motion_trip_point_sequencer_tb.sv
`timescale 1ns/1ps
module motion_trip_point_sequencer_tb;
  import mtp_pkg::*;
  typedef struct {mtp_op_t op; logic [7:0] m; logic [31:0] a; logic e; int mn;} mtp_row_t;
  logic             clk_sys, arst_n, cmd_valid, cmd_ready, seq_hold, trip_release, cmd_error;
  logic             handler, sc_wr, rel_v, rel_acc, rel_rej, go, moving;
  mtp_op_t          cmd_op;
  logic [7:0]       mask, sc;
  logic [2:0]       sc_axis, rel_axis;
  logic [31:0]      arg, target, pos, p0;
  logic [7:0][15:0] tmo;
  logic [79:0]      din;
  int               bad_count, tests_run, cyc;
  mtp_row_t         rows [14];
  mtp_axis_model far (.clk_sys, .arst_n, .go, .target, .moving, .pos);
  mtp_sequencer #(.MS_DIV(10), .SERVO_DIV(4)) uut (.clk_sys, .arst_n, .cmd_valid, .cmd_ready, .cmd_op,
    .cmd_axis_mask(mask), .cmd_seq(1'b0), .cmd_arg(arg), .seq_hold, .trip_release, .cmd_error,
    .in_position_timeout_handler(handler), .stop_code_wr(sc_wr), .stop_code_axis(sc_axis), .stop_code(sc),
    .rel_cmd_valid(rel_v), .rel_cmd_axis(rel_axis), .rel_cmd_accept(rel_acc), .rel_cmd_reject(rel_rej),
    .prof_moving({7'h0, moving}), .prof_at_slew({7'h0, moving}), .seq_moving(moving),
    .cmd_position({224'h0, pos}), .enc_position({224'h0, pos}), .path_distance(pos - p0),
    .in_position_timeout(tmo), .din_pin(din));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Offer one trip command, held for one cycle
  task automatic start(input mtp_op_t op, input logic [7:0] m, input logic [31:0] a);
    @(posedge clk_sys);
    cmd_valid <= 1'b1; cmd_op <= op; mask <= m; arg <= a;
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
  endtask
  // Bounded wait for any outcome pulse
  task automatic finish();
    cyc = 0;
    #1;
    while (!(trip_release | cmd_error | handler) && cyc < 2000) begin
      @(posedge clk_sys); #1; cyc++;
    end
  endtask
  // One relative command pulse, answer seen next cycle
  task automatic rel_pulse();
    @(posedge clk_sys) rel_v <= 1'b1;
    @(posedge clk_sys) rel_v <= 1'b0;
    #1;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Hang guard
  initial begin
    #300000;
    bad_count++;
    summarize();
  end
  initial begin
    cmd_valid = 0; rel_v = 0; go = 0; mask = 0; arg = 0; target = 0; rel_axis = 0;
    cmd_op = OP_DELAY; tmo = '0; din = '0; bad_count = 0; tests_run = 0; arst_n = 0; p0 = '0;
    rows = '{'{OP_MOTION_DONE, 8'h00, 32'h0, 1'b0, 0}, '{OP_ABS_POS, 8'h01, 32'h0, 1'b0, 0},
      '{OP_FWD_CROSS, 8'h01, 32'hFFFFFFFB, 1'b0, 0}, '{OP_REV_CROSS, 8'h01, 32'h5, 1'b0, 0},
      '{OP_IN_POS, 8'h01, 32'h0, 1'b0, 0}, '{OP_INPUT, 8'h00, 32'hFFFFFFFF, 1'b0, 0},
      '{OP_INPUT, 8'h00, 32'h0, 1'b1, 0}, '{OP_INPUT, 8'h00, 32'h51, 1'b1, 0},
      '{OP_REL_DIST, 8'h03, 32'h0, 1'b1, 0}, '{OP_REF_TIME, 8'h00, 32'h0, 1'b0, 0},
      '{OP_REF_TIME, 8'h00, 32'hFFFFFFFE, 1'b0, 0}, '{OP_REF_TIME, 8'h00, 32'h2, 1'b0, 10},
      '{OP_DELAY, 8'h00, 32'h2, 1'b0, 10}, '{OP_PATH_DIST, 8'h00, 32'h0, 1'b0, 0}};
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    @(posedge clk_sys); #1;
    chk({cmd_ready, seq_hold, sc}, {1'b1, 1'b0, 8'h00});
    // Table cases: release or refusal, with minimum wait
    foreach (rows[i]) begin
      start(rows[i].op, rows[i].m, rows[i].a);
      finish();
      chk({cmd_error, trip_release, 30'(cyc >= rows[i].mn)}, {rows[i].e, !rows[i].e, 30'h1});
      $display("row %0d done", i);
    end
    // Input wait stalls until the pin goes high
    start(OP_INPUT, 8'h00, 32'h3);
    repeat (20) @(posedge clk_sys);
    chk(seq_hold, 1'b1);
    din[2] <= 1'b1;
    finish();
    chk(trip_release, 1'b1);
    $display("input wait done");
    // In-position timeout while the axis still runs
    @(posedge clk_sys) begin
      tmo[0] <= 16'h2; go <= 1'b1; target <= 32'h3E8;
    end
    start(OP_IN_POS, 8'h01, 32'h3E8);
    finish();
    chk({handler, sc_wr, trip_release, sc_axis, sc}, {3'b110, 3'h0, 8'h63});
    rel_pulse();
    chk({rel_acc, rel_rej}, 2'b01);
    @(posedge clk_sys) go <= 1'b0;
    rel_pulse();
    chk({rel_acc, rel_rej}, 2'b10);
    $display("timeout and relative check done");
    // New move: slew, then relative and two incremental trips
    @(posedge clk_sys) begin
      p0 <= pos; go <= 1'b1; target <= pos + 32'h1F4;
    end
    start(OP_SLEW, 8'h01, 32'h0);
    finish();
    chk(trip_release, 1'b1);
    for (int k = 0; k < 3; k++) begin
      start(k == 0 ? OP_REL_DIST : OP_INC_DIST, 8'h01, k == 0 ? 32'h32 : 32'h1E);
      finish();
      chk((pos - p0) >= 50 + 30 * k && (pos - p0) <= 60 + 30 * k, 1'b1);
    end
    // Path distance from move start, then motion done at move end
    start(OP_PATH_DIST, 8'h00, 32'hA0);
    finish();
    chk((pos - p0) >= 160 && (pos - p0) <= 170, 1'b1);
    start(OP_MOTION_DONE, 8'h01, 32'h0);
    finish();
    chk({trip_release, pos == p0 + 32'h1F4}, 2'b11);
    $display("distance trips done");
    // Reset in mid-wait drops the hold, then a delay runs from fresh time
    start(OP_INPUT, 8'h00, 32'h5);
    @(posedge clk_sys) arst_n <= 1'b0;
    @(posedge clk_sys) #1;
    chk({seq_hold, cmd_ready, trip_release}, 3'b010);
    @(posedge clk_sys) arst_n <= 1'b1;
    start(OP_DELAY, 8'h00, 32'h1);
    finish();
    chk({trip_release, 31'(cyc >= 10)}, {1'b1, 31'h1});
    $display("mid-run reset done");
    summarize();
  end
endmodule // motion_trip_point_sequencer_tb
